// >>> snpo_exec_unit.sv
// executes negate, push, pop, shadow pop and power save instructions
// assumes f_rdata_i holds data at req_f_addr_i and stk_rdata_i the word
// at stk_raddr_o, both valid in the cycle the request is taken
`timescale 1ns/10ps
module snpo_exec_unit
    import snpo_pkg::*;
#(
    parameter logic [15:0] SP_RESET = 16'h0800
)(
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        req_valid_i,
    input  wire snpo_op_type req_op_i,
    input  wire logic [15:0] req_f_addr_i,
    input  wire logic        req_to_default_work_reg_i,
    input  wire logic [3:0]  req_ws_i,
    input  wire logic [3:0]  req_wd_i,
    input  wire logic        req_lit_i,
    output logic             req_ready_o,
    output logic             done_o,
    input  wire logic [15:0] f_rdata_i,
    output logic             f_we_o,
    output logic      [15:0] f_waddr_o,
    output logic      [15:0] f_wdata_o,
    input  wire logic [15:0] stk_rdata_i,
    output logic      [15:0] stk_raddr_o,
    output logic             stk_we_o,
    output logic      [15:0] stk_waddr_o,
    output logic      [15:0] stk_wdata_o,
    input  wire logic        w_load_i,
    input  wire logic [3:0]  w_load_sel_i,
    input  wire logic [15:0] w_load_data_i,
    input  wire logic [3:0]  w_rd_sel_i,
    output logic      [15:0] w_rd_data_o,
    output logic      [15:0] sp_o,
    output logic      [4:0]  status_o,
    input  wire logic        wdt_timeout_i,
    input  wire logic        wake_i,
    output logic             watchdog_timeout_flag_o,
    output logic             sleep_o,
    output logic             idle_o
);
    typedef struct packed {
        snpo_st_type                 st;
        logic [W_COUNT-1:0][15:0]    w;
        logic [4:0]                  sr;
        logic [SHADOW_CNT-1:0][15:0] shw;
        logic [4:0]                  shsr;
        logic [3:0]                  idx;
        logic                        wdt_flag;
        logic                        sleep;
        logic                        idle;
        logic                        done;
        logic                        f_we;
        logic [15:0]                 f_addr;
        logic [15:0]                 f_data;
        logic                        s_we;
        logic [15:0]                 s_addr;
        logic [15:0]                 s_data;
    } snpo_state_type;

    snpo_state_type state_ff;
    snpo_state_type nxt_state;
    logic           accept;
    logic [15:0]    twc_src;
    logic [15:0]    twc_res;
    logic [4:0]     twc_flags;
    logic [15:0]    sp_cur;

    assign sp_cur      = state_ff.w[SP_IDX];
    assign req_ready_o = (state_ff.st == ST_RUN) && !state_ff.sleep
                         && !state_ff.idle;
    assign accept      = req_valid_i && req_ready_o;
    assign twc_src     = (req_op_i == OP_TWC_W) ? state_ff.w[req_ws_i]
                                                : f_rdata_i;
    assign stk_raddr_o = sp_cur - STACK_STEP;

    snpo_negate u_negate (
        .src_i   (twc_src),
        .res_o   (twc_res),
        .flags_o (twc_flags)
    );

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.done = 1'b0;
        nxt_state.f_we = 1'b0;
        nxt_state.s_we = 1'b0;
        if (wake_i) begin
            nxt_state.sleep = 1'b0;
            nxt_state.idle  = 1'b0;
        end
        if (w_load_i) begin
            nxt_state.w[w_load_sel_i] = w_load_data_i;
        end
        unique case (state_ff.st)
            ST_RUN: begin
                if (accept) begin
                    nxt_state.done = 1'b1;
                    unique case (req_op_i)
                        OP_TWC_F: begin
                            if (req_to_default_work_reg_i) begin
                                nxt_state.w[DFLT_W_IDX] = twc_res; // [RULE1]
                            end else begin
                                nxt_state.f_we   = 1'b1;         // [RULE1]
                                nxt_state.f_addr = req_f_addr_i;
                                nxt_state.f_data = twc_res;
                            end
                            nxt_state.sr = twc_flags;            // [RULE1]
                        end
                        OP_TWC_W: begin
                            nxt_state.w[req_wd_i] = twc_res;     // [RULE1]
                            nxt_state.sr          = twc_flags;   // [RULE1]
                        end
                        OP_POP_F: begin
                            nxt_state.w[SP_IDX] = stk_raddr_o;   // [RULE2]
                            nxt_state.f_we      = 1'b1;          // [RULE2]
                            nxt_state.f_addr    = req_f_addr_i;
                            nxt_state.f_data    = stk_rdata_i;
                        end
                        OP_POP_W: begin
                            nxt_state.w[SP_IDX]   = stk_raddr_o; // [RULE3]
                            nxt_state.w[req_wd_i] = stk_rdata_i; // [RULE3]
                        end
                        OP_POP_D: begin
                            nxt_state.w[SP_IDX] = stk_raddr_o;
                            nxt_state.w[req_wd_i + 4'h1] = stk_rdata_i;
                            nxt_state.idx  = req_wd_i;
                            nxt_state.st   = ST_POP2;            // [RULE3]
                            nxt_state.done = 1'b0;
                        end
                        OP_PUSH_F: begin
                            nxt_state.s_we   = 1'b1;             // [RULE4]
                            nxt_state.s_addr = sp_cur;
                            nxt_state.s_data = f_rdata_i;
                            nxt_state.w[SP_IDX] = sp_cur + STACK_STEP;
                        end
                        OP_PUSH_W: begin
                            nxt_state.s_we   = 1'b1;             // [RULE5]
                            nxt_state.s_addr = sp_cur;
                            nxt_state.s_data = state_ff.w[req_ws_i];
                            nxt_state.w[SP_IDX] = sp_cur + STACK_STEP;
                        end
                        OP_PUSH_D: begin
                            nxt_state.s_we   = 1'b1;             // [RULE6]
                            nxt_state.s_addr = sp_cur;
                            nxt_state.s_data = state_ff.w[req_ws_i];
                            nxt_state.w[SP_IDX] = sp_cur + STACK_STEP;
                            nxt_state.idx  = req_ws_i + 4'h1;
                            nxt_state.st   = ST_PUSH2;           // [RULE6]
                            nxt_state.done = 1'b0;
                        end
                        OP_PUSH_S: begin
                            nxt_state.shw  = state_ff.w[SHADOW_CNT-1:0];
                            nxt_state.shsr = state_ff.sr;        // [RULE8]
                        end
                        OP_POP_S: begin
                            nxt_state.w[SHADOW_CNT-1:0] = state_ff.shw;
                            nxt_state.sr = state_ff.shsr;        // [RULE8]
                        end
                        OP_PSAVE: begin
                            nxt_state.wdt_flag = 1'b0;           // [RULE7]
                            nxt_state.sleep = !req_lit_i;        // [RULE7]
                            nxt_state.idle  = req_lit_i;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_PUSH2: begin
                nxt_state.s_we   = 1'b1;                         // [RULE6]
                nxt_state.s_addr = sp_cur;
                nxt_state.s_data = state_ff.w[state_ff.idx];
                nxt_state.w[SP_IDX] = sp_cur + STACK_STEP;
                nxt_state.st   = ST_RUN;
                nxt_state.done = 1'b1;
            end
            ST_POP2: begin
                nxt_state.w[SP_IDX]       = stk_raddr_o;
                nxt_state.w[state_ff.idx] = stk_rdata_i;         // [RULE3]
                nxt_state.st   = ST_RUN;
                nxt_state.done = 1'b1;
            end
            default: begin
                nxt_state.st = ST_RUN;
            end
        endcase
        // timeout beats the clear from a power-save instruction
        if (wdt_timeout_i) begin
            nxt_state.wdt_flag = 1'b1;                           // [RULE7]
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff         <= '0;
            state_ff.st      <= ST_RUN;
            state_ff.w       <= {W_COUNT{W_RST}};
            state_ff.w[SP_IDX] <= SP_RESET;
            state_ff.sr      <= SR_RST;
            state_ff.shsr    <= SR_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign done_o                  = state_ff.done;
    assign f_we_o                  = state_ff.f_we;
    assign f_waddr_o               = state_ff.f_addr;
    assign f_wdata_o               = state_ff.f_data;
    assign stk_we_o                = state_ff.s_we;
    assign stk_waddr_o             = state_ff.s_addr;
    assign stk_wdata_o             = state_ff.s_data;
    assign w_rd_data_o             = state_ff.w[w_rd_sel_i];
    assign sp_o                    = sp_cur;
    assign status_o                = state_ff.sr;
    assign watchdog_timeout_flag_o = state_ff.wdt_flag;
    assign sleep_o                 = state_ff.sleep;
    assign idle_o                  = state_ff.idle;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    property p_twc_w;
        accept && req_op_i == OP_TWC_W && req_wd_i != SP_IDX && !w_load_i
        |=> state_ff.w[$past(req_wd_i)] == ~$past(twc_src) + 16'h0001
            && status_o == $past(twc_flags);
    endproperty
    a_twc_w: assert property (p_twc_w) else $error("negate Ws"); // [RULE1]

    property p_twc_f;
        accept && req_op_i == OP_TWC_F && !req_to_default_work_reg_i
        |=> f_we_o && f_wdata_o == ~$past(f_rdata_i) + 16'h0001
            && f_waddr_o == $past(req_f_addr_i);
    endproperty
    a_twc_f: assert property (p_twc_f) else $error("negate f"); // [RULE1]

    property p_pop_f;
        accept && req_op_i == OP_POP_F && !w_load_i
        |=> f_we_o && f_wdata_o == $past(stk_rdata_i)
            && sp_o == $past(sp_o) - STACK_STEP && $stable(status_o);
    endproperty
    a_pop_f: assert property (p_pop_f) else $error("pop to f"); // [RULE2]

    property p_pop_w;
        accept && req_op_i == OP_POP_W && !w_load_i && req_wd_i != SP_IDX
        |=> state_ff.w[$past(req_wd_i)] == $past(stk_rdata_i)
            && $stable(status_o) && done_o;
    endproperty
    a_pop_w: assert property (p_pop_w) else $error("pop to Wd"); // [RULE3]

    property p_push_f;
        accept && req_op_i == OP_PUSH_F && !w_load_i
        |=> stk_we_o && stk_wdata_o == $past(f_rdata_i)
            && stk_waddr_o == $past(sp_o) && $stable(status_o);
    endproperty
    a_push_f: assert property (p_push_f) else $error("push f"); // [RULE4]

    property p_push_w;
        accept && req_op_i == OP_PUSH_W
        |=> stk_we_o && stk_wdata_o == $past(state_ff.w[req_ws_i])
            && stk_waddr_o == $past(sp_o) && $stable(status_o);
    endproperty
    a_push_w: assert property (p_push_w) else $error("push Ws"); // [RULE5]

    property p_push_d;
        accept && req_op_i == OP_PUSH_D
        |=> stk_we_o && !req_ready_o && !done_o
            ##1 stk_we_o && done_o && req_ready_o && $stable(status_o);
    endproperty
    a_push_d: assert property (p_push_d) else $error("double push"); // [RULE6]

    property p_psave;
        accept && req_op_i == OP_PSAVE && !wdt_timeout_i && !wake_i
        |=> !watchdog_timeout_flag_o && sleep_o == !$past(req_lit_i)
            && idle_o == $past(req_lit_i) && !req_ready_o;
    endproperty
    a_psave: assert property (p_psave) else $error("power save"); // [RULE7]

    property p_wdt_set;
        wdt_timeout_i |=> watchdog_timeout_flag_o;
    endproperty
    a_wdt_set: assert property (p_wdt_set) else $error("wdt lost"); // [RULE7]

    property p_pop_s;
        accept && req_op_i == OP_POP_S |=> status_o == $past(state_ff.shsr);
    endproperty
    a_pop_s: assert property (p_pop_s) else $error("shadow pop"); // [RULE8]

    c_push_d: cover property (accept && req_op_i == OP_PUSH_D ##2 done_o);
    c_twc:    cover property (accept && req_op_i == OP_TWC_W
                              ##1 status_o[SR_Z]);
    c_sleep:  cover property (accept && req_op_i == OP_PSAVE ##1 sleep_o);
    c_pop_d:  cover property (accept && req_op_i == OP_POP_D ##2 done_o);
endmodule // snpo_exec_unit

// >>> snpo_pkg.sv
// constants and types for the stack, negate and power-save execution unit
// assumes a 16-bit core with sixteen working registers, W15 as stack pointer
// Overview of operation
// RULE1: negate f or Ws, flags C DC N OV Z
// RULE2: pop stack top into file register, flags kept
// RULE3: pop stack top into Wd, flags kept
// RULE4: push file register onto stack, flags kept
// RULE5: push Ws onto stack, flags kept
// RULE6: double push Ws and Ws+1, two cycles
// RULE7: power save literal picks sleep or idle
// RULE8: shadow pop restores W0-W3 and all flags
package snpo_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned W_COUNT    = 16;
    localparam int unsigned SHADOW_CNT = 4;
    localparam logic [3:0]  SP_IDX     = 4'hF;
    localparam logic [3:0]  DFLT_W_IDX = 4'h0;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] W_RST      = 16'h0000;
    localparam logic [4:0]  SR_RST     = 5'h00;
    // status flag positions
    localparam int unsigned SR_C  = 0;
    localparam int unsigned SR_Z  = 1;
    localparam int unsigned SR_OV = 2;
    localparam int unsigned SR_N  = 3;
    localparam int unsigned SR_DC = 4;
    // instruction cycle counts
    localparam int unsigned CYC_SINGLE = 1;
    localparam int unsigned CYC_DOUBLE = 2;

    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,
        OP_TWC_F   = 4'h1,
        OP_TWC_W   = 4'h2,
        OP_POP_F   = 4'h3,
        OP_POP_W   = 4'h4,
        OP_POP_D   = 4'h5,
        OP_PUSH_F  = 4'h6,
        OP_PUSH_W  = 4'h7,
        OP_PUSH_D  = 4'h8,
        OP_PUSH_S  = 4'h9,
        OP_POP_S   = 4'hA,
        OP_PSAVE   = 4'hB
    } snpo_op_type;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_PUSH2 = 2'h1,
        ST_POP2  = 2'h2
    } snpo_st_type;
endpackage

// >>> snpo_negate.sv
// two's complement of a 16-bit word with the arithmetic flags
// assumes the caller picks the source and decides whether flags are kept
`timescale 1ns/10ps
module snpo_negate
    import snpo_pkg::*;
(
    input  wire logic [15:0] src_i,
    output logic      [15:0] res_o,
    output logic      [4:0]  flags_o
);
    always_comb begin
        res_o              = (~src_i) + 16'h0001;      // [RULE1]
        flags_o            = SR_RST;
        flags_o[SR_C]      = (src_i == 16'h0000);      // no borrow out of 0-x
        flags_o[SR_DC]     = (src_i[3:0] == 4'h0);
        flags_o[SR_N]      = res_o[15];
        flags_o[SR_OV]     = (src_i == 16'h8000);
        flags_o[SR_Z]      = (res_o == 16'h0000);
    end
endmodule // snpo_negate

// >>> stack_negate_powersave_ops_bench.sv
// directed testbench for the stack, negate and power-save execution unit
// assumes snpo_pkg and snpo_exec_unit are compiled first; stack memory here
`timescale 1ns/10ps
module stack_negate_powersave_ops_bench
    import snpo_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        req_valid_i = 1'b0;
    snpo_op_type req_op_i = OP_NOP;
    logic [15:0] req_f_addr_i = 16'h1234;
    logic        req_to_default_work_reg_i = 1'b0;
    logic [3:0]  req_ws_i = 4'h0;
    logic [3:0]  req_wd_i = 4'h0;
    logic        req_lit_i = 1'b0;
    logic        req_ready_o, done_o, f_we_o, stk_we_o;
    logic [15:0] f_rdata_i = 16'h0000;
    logic [15:0] f_waddr_o, f_wdata_o, stk_raddr_o, stk_waddr_o, stk_wdata_o;
    logic [15:0] stk_rdata_i;
    logic        w_load_i = 1'b0;
    logic [3:0]  w_load_sel_i = 4'h0;
    logic [15:0] w_load_data_i = 16'h0000;
    logic [3:0]  w_rd_sel_i = 4'h0;
    logic [15:0] w_rd_data_o, sp_o;
    logic [4:0]  status_o;
    logic        wdt_timeout_i = 1'b0;
    logic        wake_i = 1'b0;
    logic        watchdog_timeout_flag_o, sleep_o, idle_o;
    logic [15:0] mem [0:63];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    snpo_exec_unit uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .req_valid_i(req_valid_i), .req_op_i(req_op_i),
        .req_f_addr_i(req_f_addr_i), .req_to_default_work_reg_i(req_to_default_work_reg_i),
        .req_ws_i(req_ws_i), .req_wd_i(req_wd_i), .req_lit_i(req_lit_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .f_rdata_i(f_rdata_i),
        .f_we_o(f_we_o), .f_waddr_o(f_waddr_o), .f_wdata_o(f_wdata_o),
        .stk_rdata_i(stk_rdata_i), .stk_raddr_o(stk_raddr_o),
        .stk_we_o(stk_we_o), .stk_waddr_o(stk_waddr_o),
        .stk_wdata_o(stk_wdata_o), .w_load_i(w_load_i),
        .w_load_sel_i(w_load_sel_i), .w_load_data_i(w_load_data_i),
        .w_rd_sel_i(w_rd_sel_i), .w_rd_data_o(w_rd_data_o), .sp_o(sp_o),
        .status_o(status_o), .wdt_timeout_i(wdt_timeout_i),
        .wake_i(wake_i), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
        .sleep_o(sleep_o), .idle_o(idle_o));

    // stack memory answering at the read address in the same cycle
    always @(posedge clk_sys_i)
        if (stk_we_o) mem[stk_waddr_o[6:1]] <= stk_wdata_o;
    always_comb stk_rdata_i = mem[stk_raddr_o[6:1]];

    task automatic end_sim();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic issue(input snpo_op_type op, input logic [3:0] ws, wd,
                         input logic tw, lit, input logic [15:0] fd);
        int n;
        n = 0;
        @(posedge clk_sys_i); #1;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i); #1;
            n++;
        end
        chk("ready before request", 16'h0001, 16'(req_ready_o));
        req_op_i = op; req_ws_i = ws; req_wd_i = wd;
        req_to_default_work_reg_i = tw; req_lit_i = lit; f_rdata_i = fd;
        req_valid_i = 1'b1;
        @(posedge clk_sys_i); #1;
        req_valid_i = 1'b0;
    endtask

    task automatic wload(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_sys_i); #1;
        w_load_i = 1'b1; w_load_sel_i = s; w_load_data_i = d;
        @(posedge clk_sys_i); #1;
        w_load_i = 1'b0;
    endtask

    task automatic rdw(input logic [3:0] s, input logic [15:0] e);
        w_rd_sel_i = s;
        #1;
        chk("w_rd_data", e, w_rd_data_o);
    endtask

    task automatic t_twc();
        issue(OP_TWC_F, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk("f_we", 16'h0001, 16'(f_we_o));
        chk("f_wdata", 16'h0000, f_wdata_o);
        chk("status zero src", 16'h0013, 16'(status_o));
        chk("done", 16'h0001, 16'(done_o));
        issue(OP_TWC_F, 4'h0, 4'h0, 1'b1, 1'b0, 16'h0001);
        chk("f_we to w0", 16'h0000, 16'(f_we_o));
        chk("status one", 16'h0008, 16'(status_o));
        rdw(DFLT_W_IDX, 16'hFFFF);
        wload(4'h3, 16'h8000);
        issue(OP_TWC_W, 4'h3, 4'h5, 1'b0, 1'b0, 16'h0000);
        chk("status min", 16'h001C, 16'(status_o));
        rdw(4'h5, 16'h8000);
    endtask

    task automatic t_push_pop();
        wload(4'h2, 16'hA55A);
        issue(OP_PUSH_W, 4'h2, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk("stk_we", 16'h0001, 16'(stk_we_o));
        chk("stk_waddr", 16'h0800, stk_waddr_o);
        chk("stk_wdata", 16'hA55A, stk_wdata_o);
        chk("sp", 16'h0802, sp_o);
        chk("status kept", 16'h001C, 16'(status_o));
        issue(OP_PUSH_F, 4'h0, 4'h0, 1'b0, 1'b0, 16'hBEEF);
        chk("stk_waddr f", 16'h0802, stk_waddr_o);
        chk("stk_wdata f", 16'hBEEF, stk_wdata_o);
        chk("status kept f", 16'h001C, 16'(status_o));
        issue(OP_POP_F, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk("f_we pop", 16'h0001, 16'(f_we_o));
        chk("f_waddr pop", 16'h1234, f_waddr_o);
        chk("f_wdata pop", 16'hBEEF, f_wdata_o);
        chk("status pop f", 16'h001C, 16'(status_o));
        issue(OP_POP_W, 4'h0, 4'h7, 1'b0, 1'b0, 16'h0000);
        chk("sp pop", 16'h0800, sp_o);
        chk("status pop w", 16'h001C, 16'(status_o));
        rdw(4'h7, 16'hA55A);
    endtask

    task automatic t_double();
        wload(4'h4, 16'h1111);
        wload(4'h5, 16'h2222);
        issue(OP_PUSH_D, 4'h4, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk("first word", 16'h1111, stk_wdata_o);
        chk("ready second", 16'h0000, 16'(req_ready_o));
        chk("done early", 16'h0000, 16'(done_o));
        @(posedge clk_sys_i); #1;
        chk("second we", 16'h0001, 16'(stk_we_o));
        chk("second addr", 16'h0802, stk_waddr_o);
        chk("second word", 16'h2222, stk_wdata_o);
        chk("done double", 16'h0001, 16'(done_o));
        chk("sp double", 16'h0804, sp_o);
        chk("status double", 16'h001C, 16'(status_o));
        issue(OP_POP_D, 4'h0, 4'h8, 1'b0, 1'b0, 16'h0000);
        chk("pop d busy", 16'h0000, 16'(req_ready_o));
        chk("pop d done early", 16'h0000, 16'(done_o));
        rdw(4'h9, 16'h2222);
        @(posedge clk_sys_i); #1;
        chk("sp pop d", 16'h0800, sp_o);
        chk("pop d done", 16'h0001, 16'(done_o));
        rdw(4'h8, 16'h1111);
    endtask

    task automatic t_shadow();
        issue(OP_PUSH_S, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        wload(DFLT_W_IDX, 16'h0055);
        issue(OP_TWC_F, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        issue(OP_POP_S, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk("status shadow", 16'h001C, 16'(status_o));
        rdw(DFLT_W_IDX, 16'hFFFF);
    endtask

    task automatic t_power(input logic lit);
        @(posedge clk_sys_i); #1;
        wdt_timeout_i = 1'b1;
        @(posedge clk_sys_i); #1;
        wdt_timeout_i = 1'b0;
        chk("wdt flag set", 16'h0001, 16'(watchdog_timeout_flag_o));
        issue(OP_PSAVE, 4'h0, 4'h0, 1'b0, lit, 16'h0000);
        chk("sleep", 16'(!lit), 16'(sleep_o));
        chk("idle", 16'(lit), 16'(idle_o));
        chk("wdt clear", 16'h0000, 16'(watchdog_timeout_flag_o));
        req_op_i = OP_TWC_F;
        req_valid_i = 1'b1;
        @(posedge clk_sys_i); #1;
        req_valid_i = 1'b0;
        wake_i = 1'b1;
        chk("ignored", 16'h0000, 16'(f_we_o));
        @(posedge clk_sys_i); #1;
        wake_i = 1'b0;
        chk("awake", 16'h0000, 16'({sleep_o, idle_o}));
        chk("ready awake", 16'h0001, 16'(req_ready_o));
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        chk("sp reset", 16'h0800, sp_o);
        chk("status reset", 16'h0000, 16'(status_o));
        chk("ready reset", 16'h0001, 16'(req_ready_o));
        t_twc();
        t_push_pop();
        t_double();
        t_shadow();
        t_power(1'b0);
        t_power(1'b1);
        end_sim();
    end
endmodule // stack_negate_powersave_ops_bench
